// File: verilog/fpi_regs.svh
`ifndef FPI_REGS_SVH
`define FPI_REGS_SVH

// ============================================================
// Assembly instances
`define FPI_INST_UP_LEG 8'h65
`define FPI_INST_DN_LEG 8'h66
`define FPI_INST_UP_DET 8'h67
`define FPI_INST_DN_DET 8'h68
`define FPI_INST_UP_AUX 8'h81
`define FPI_INST_DN_AUX 8'h82

// ============================================================
// Assembly lengths in 16-bit words
`define FPI_DN_LEN_STD  7'h03
`define FPI_DN_LEN_AUX  7'h02
`define FPI_UP_LEN_LEG  7'h72
`define FPI_UP_LEN_DET  7'h76
`define FPI_UP_LEN_AUX  7'h78
`define FPI_BUF_WORDS   120
`define FPI_NPTS        96

// ============================================================
// Word offsets and the reset bit
`define FPI_W_CONN0     7'h00
`define FPI_W_CONN1     7'h01
`define FPI_W_CONC      7'h02
`define FPI_W_ALM1      7'h62
`define FPI_W_ALM2      7'h68
`define FPI_W_SUM       7'h6e
`define FPI_W_MACH      7'h71
`define FPI_W_FIND      7'h72
`define FPI_W_FEND      7'h76
`define FPI_DN_W_RST    7'h02
`define FPI_RST_BIT     4'h0

// ============================================================
// Controller registers (byte addresses) and fields
`define FPI_A_CTRL      12'h000
`define FPI_A_CONN      12'h004
`define FPI_A_STAT      12'h008
`define FPI_A_BUF       12'h200
`define FPI_A_BUF_END   12'h3e0
`define FPI_C_GO        5'h00
`define FPI_C_MODE      5'h01
`define FPI_C_ABORT     5'h03
`define FPI_C_FRST      5'h08
`define FPI_S_BUSY      5'h00
`define FPI_S_DONE      5'h01
`define FPI_S_LEN       5'h08
`define FPI_S_INST      5'h10

`endif

// File: verilog/fpi_pkg.sv
package fpi_pkg;

	typedef enum logic [1:0] {FPI_MODE_LEG, FPI_MODE_DET, FPI_MODE_AUX} fpi_mode_type;
	typedef enum logic [1:0] {FPI_D_IDLE, FPI_D_RECV, FPI_D_SEND} fpi_dst_type;
	typedef enum logic [1:0] {FPI_M_IDLE, FPI_M_SEND, FPI_M_WAIT} fpi_mst_type;

	typedef struct packed {
		fpi_dst_type st;
		logic [7:0]  dn_inst;
		logic [6:0]  cnt;
		logic [6:0]  len;
		logic [31:0] conn;
		logic        rst_new;
		logic        rst_prev;
		logic        hb;
		logic        up_valid;
		logic        up_last;
		logic [7:0]  up_inst;
		logic [15:0] up_word;
		logic        fault_clr;
		logic        frame_err;
		logic        m_crit;
		logic        m_maint;
		logic        m_alm1;
		logic        m_alm2;
		logic        m_power;
		logic [2:0]  a_crit;
		logic [2:0]  a_maint;
		logic [2:0]  a_alm1;
		logic [2:0]  a_alm2;
		logic [2:0]  a_active;
	} fpi_dev_type;

	typedef struct packed {
		fpi_mst_type  st;
		logic         wr_pend;
		logic         rd_pend;
		logic [11:0]  addr;
		logic [31:0]  hrdata;
		logic         hreadyout;
		fpi_mode_type mode;
		logic         frst;
		logic [31:0]  conn;
		logic         busy;
		logic         done;
		logic [7:0]   up_inst;
		logic [6:0]   up_len;
		logic [6:0]   cnt;
		logic         dn_valid;
		logic         dn_last;
		logic [7:0]   dn_inst;
		logic [15:0]  dn_word;
		logic [119:0][15:0] mem;
	} fpi_mst_state_type;

endpackage

// File: verilog/fpi_link_if.sv
`timescale 1ns/1ps

interface fpi_link_if (
	input wire logic hclk,
	input wire logic hresetn
);
	logic        dn_valid;
	logic        dn_last;
	logic [7:0]  dn_inst;
	logic [15:0] dn_word;
	logic        up_valid;
	logic        up_last;
	logic [7:0]  up_inst;
	logic [15:0] up_word;

	modport dev (
		input  hclk, hresetn, dn_valid, dn_last, dn_inst, dn_word,
		output up_valid, up_last, up_inst, up_word
	);
	modport mst (
		input  hclk, hresetn, up_valid, up_last, up_inst, up_word,
		output dn_valid, dn_last, dn_inst, dn_word
	);
endinterface : fpi_link_if

// File: verilog/fpi_device.sv
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fpi_regs.svh"

module fpi_device
	import fpi_pkg::*;
(
	// Link
	fpi_link_if.dev                    lk,
	// Measurements and unit status
	input  wire logic [`FPI_NPTS*16-1:0] conc_in,
	input  wire logic [`FPI_NPTS-1:0]    alm1_in,
	input  wire logic [`FPI_NPTS-1:0]    alm2_in,
	input  wire logic [5:0]              unit_crit,
	input  wire logic [5:0]              unit_maint,
	input  wire logic [5:0]              unit_active,
	input  wire logic                    power_in,
	input  wire logic [63:0]             fault_ind_in,
	// Link results
	output logic                         fault_clr,
	output logic                         frame_err,
	output logic [31:0]                  conn_stat,
	// Machine flags
	output logic                         mach_crit,
	output logic                         mach_maint,
	output logic                         mach_alm1,
	output logic                         mach_alm2,
	output logic                         power_on,
	// Analyzer flags
	output logic [2:0]                   anl_crit,
	output logic [2:0]                   anl_maint,
	output logic [2:0]                   anl_alm1,
	output logic [2:0]                   anl_alm2,
	output logic [2:0]                   anl_active
);

	fpi_dev_type      s_r;
	fpi_dev_type      s_nxt;
	logic [5:0]       u_alm1;
	logic [5:0]       u_alm2;
	logic [5:0][7:0]  sum_byte;
	logic [2:0]       an_alm1;
	logic [2:0]       an_alm2;
	logic [2:0]       an_crit;
	logic [2:0]       an_maint;
	logic [2:0]       an_active;
	logic [7:0]       mach_byte;

	// ============================================================
	// Per-unit and per-analyzer flags
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_unit
			assign u_alm1[g] = |alm1_in[g*16 +: 16];
			assign u_alm2[g] = |alm2_in[g*16 +: 16];
			// Bit 6 stays zero
			assign sum_byte[g] = {s_r.hb, 1'b0, power_in, unit_active[g], u_alm2[g],
				u_alm1[g], unit_maint[g], unit_crit[g]};
		end
		for (g = 0; g < 3; g++) begin : g_anl
			assign an_alm1[g]   = |alm1_in[g*32 +: 32];
			assign an_alm2[g]   = |alm2_in[g*32 +: 32];
			assign an_crit[g]   = |unit_crit[g*2 +: 2];
			assign an_maint[g]  = |unit_maint[g*2 +: 2];
			assign an_active[g] = |unit_active[g*2 +: 2];
		end
	endgenerate

	assign mach_byte = {s_r.hb, 1'b0, power_in, |unit_active, |alm2_in, |alm1_in,
		|unit_maint, |unit_crit};

	// ============================================================
	// Next state
	always_comb begin
		logic [6:0]  c;
		logic [6:0]  off;
		logic [7:0]  inst;
		logic [6:0]  expect_len;
		logic [15:0] w;
		s_nxt      = s_r;
		c          = 7'h00;
		off        = 7'h00;
		inst       = 8'h00;
		expect_len = 7'h00;
		w          = 16'h0000;
		s_nxt.up_valid  = 1'b0;
		s_nxt.up_last   = 1'b0;
		s_nxt.fault_clr = 1'b0;
		s_nxt.frame_err = 1'b0;

		s_nxt.m_crit   = |unit_crit;
		s_nxt.m_maint  = |unit_maint;
		s_nxt.m_power  = power_in;
		s_nxt.m_alm1   = |alm1_in;
		s_nxt.m_alm2   = |alm2_in;
		s_nxt.a_crit   = an_crit;
		s_nxt.a_maint  = an_maint;
		s_nxt.a_alm1   = an_alm1;
		s_nxt.a_alm2   = an_alm2;
		s_nxt.a_active = an_active;

		case (s_r.st)
			FPI_D_IDLE, FPI_D_RECV: begin
				if (lk.dn_valid) begin
					c    = (s_r.st == FPI_D_IDLE) ? 7'h00 : s_r.cnt;
					inst = (s_r.st == FPI_D_IDLE) ? lk.dn_inst : s_r.dn_inst;
					s_nxt.dn_inst = inst;
					case (c)
						`FPI_W_CONN0:  s_nxt.conn[15:0]  = lk.dn_word;
						`FPI_W_CONN1:  s_nxt.conn[31:16] = lk.dn_word;
						`FPI_DN_W_RST: s_nxt.rst_new     = lk.dn_word[`FPI_RST_BIT];
						default:       s_nxt.rst_new     = s_r.rst_new;
					endcase
					s_nxt.cnt = c + 7'h01;
					s_nxt.st  = FPI_D_RECV;
					if (lk.dn_last) begin
						case (inst)
							`FPI_INST_DN_LEG: expect_len = `FPI_DN_LEN_STD;
							`FPI_INST_DN_DET: expect_len = `FPI_DN_LEN_STD;
							`FPI_INST_DN_AUX: expect_len = `FPI_DN_LEN_AUX;
							default:          expect_len = 7'h00;
						endcase
						if (expect_len != 7'h00 && c + 7'h01 == expect_len) begin
							// Only three-word frames carry the reset word
							if (expect_len == `FPI_DN_LEN_STD) begin
								s_nxt.rst_prev  = s_nxt.rst_new;
								s_nxt.fault_clr = s_r.rst_prev & ~s_nxt.rst_new;
							end
							case (inst)
								`FPI_INST_DN_LEG: begin
									s_nxt.up_inst = `FPI_INST_UP_LEG;
									s_nxt.len     = `FPI_UP_LEN_LEG;
								end
								`FPI_INST_DN_DET: begin
									s_nxt.up_inst = `FPI_INST_UP_DET;
									s_nxt.len     = `FPI_UP_LEN_DET;
								end
								default: begin
									s_nxt.up_inst = `FPI_INST_UP_AUX;
									s_nxt.len     = `FPI_UP_LEN_AUX;
								end
							endcase
							s_nxt.cnt = 7'h00;
							s_nxt.st  = FPI_D_SEND;
						end else begin
							// Wrong length or unknown instance: no answer
							s_nxt.frame_err = 1'b1;
							s_nxt.st        = FPI_D_IDLE;
						end
					end
				end
			end
			FPI_D_SEND: begin
				if (s_r.cnt < `FPI_W_CONC) begin
					w = s_r.cnt[0] ? s_r.conn[31:16] : s_r.conn[15:0];
				end else if (s_r.cnt < `FPI_W_ALM1) begin
					off = s_r.cnt - `FPI_W_CONC;
					w   = conc_in[int'(off)*16 +: 16];
				end else if (s_r.cnt < `FPI_W_ALM2) begin
					off = s_r.cnt - `FPI_W_ALM1;
					w   = alm1_in[int'(off)*16 +: 16];
				end else if (s_r.cnt < `FPI_W_SUM) begin
					off = s_r.cnt - `FPI_W_ALM2;
					w   = alm2_in[int'(off)*16 +: 16];
				end else if (s_r.cnt < `FPI_W_MACH) begin
					off = s_r.cnt - `FPI_W_SUM;
					w   = {sum_byte[int'(off)*2+1], sum_byte[int'(off)*2]};
				end else if (s_r.cnt == `FPI_W_MACH) begin
					w = {8'h00, mach_byte};
				end else if (s_r.cnt < `FPI_W_FEND) begin
					off = s_r.cnt - `FPI_W_FIND;
					w   = fault_ind_in[int'(off)*16 +: 16];
				end else begin
					w = 16'h0000;
				end
				s_nxt.up_valid = 1'b1;
				s_nxt.up_word  = w;
				s_nxt.up_last  = (s_r.cnt == s_r.len - 7'h01);
				s_nxt.cnt      = s_r.cnt + 7'h01;
				if (s_nxt.up_last) begin
					s_nxt.st = FPI_D_IDLE;
					s_nxt.hb = ~s_r.hb;
				end
			end
			default: s_nxt.st = FPI_D_IDLE;
		endcase
	end

	// ============================================================
	// State register
	always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
		if (!lk.hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign lk.up_valid  = s_r.up_valid;
	assign lk.up_last   = s_r.up_last;
	assign lk.up_inst   = s_r.up_inst;
	assign lk.up_word   = s_r.up_word;
	assign fault_clr    = s_r.fault_clr;
	assign frame_err    = s_r.frame_err;
	assign conn_stat    = s_r.conn;
	assign mach_crit    = s_r.m_crit;
	assign mach_maint   = s_r.m_maint;
	assign mach_alm1    = s_r.m_alm1;
	assign mach_alm2    = s_r.m_alm2;
	assign power_on     = s_r.m_power;
	assign anl_crit     = s_r.a_crit;
	assign anl_maint    = s_r.a_maint;
	assign anl_alm1     = s_r.a_alm1;
	assign anl_alm2     = s_r.a_alm2;
	assign anl_active   = s_r.a_active;

endmodule : fpi_device

// File: verilog/fpi_master.sv
`timescale 1ns/1ps
`include "fpi_regs.svh"

module fpi_master
	import fpi_pkg::*;
(
	// Link
	fpi_link_if.mst            lk,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata
);

	fpi_mst_state_type s_r;
	fpi_mst_state_type s_nxt;

	// ============================================================
	// Next state
	always_comb begin
		logic        acc;
		logic [31:0] rd;
		logic [11:0] bidx;
		logic [6:0]  dlen;
		s_nxt = s_r;
		acc   = hsel && htrans[1] && hready && (hsize == 3'h2);
		rd    = 32'h0000_0000;
		bidx  = 12'h000;
		dlen  = (s_r.mode == FPI_MODE_AUX) ? `FPI_DN_LEN_AUX : `FPI_DN_LEN_STD;
		s_nxt.dn_valid = 1'b0;
		s_nxt.dn_last  = 1'b0;

		// Reads take one wait state so a preceding write is visible
		case (s_r.addr)
			`FPI_A_CTRL: begin
				rd[`FPI_C_MODE +: 2] = s_r.mode;
				rd[`FPI_C_FRST]      = s_r.frst;
			end
			`FPI_A_CONN: rd = s_r.conn;
			`FPI_A_STAT: begin
				rd[`FPI_S_BUSY]     = s_r.busy;
				rd[`FPI_S_DONE]     = s_r.done;
				rd[`FPI_S_LEN +: 7] = s_r.up_len;
				rd[`FPI_S_INST +: 8] = s_r.up_inst;
			end
			default: begin
				if (s_r.addr >= `FPI_A_BUF && s_r.addr < `FPI_A_BUF_END) begin
					bidx = (s_r.addr - `FPI_A_BUF) >> 2;
					rd   = {16'h0000, s_r.mem[bidx[6:0]]};
				end
			end
		endcase
		if (s_r.rd_pend) begin
			s_nxt.hrdata    = rd;
			s_nxt.hreadyout = 1'b1;
		end

		s_nxt.wr_pend = acc && hwrite;
		s_nxt.rd_pend = acc && !hwrite;
		if (acc) begin
			s_nxt.addr = haddr[11:0];
			if (!hwrite) begin
				s_nxt.hreadyout = 1'b0;
			end
		end

		case (s_r.st)
			FPI_M_SEND: begin
				s_nxt.dn_valid = 1'b1;
				case (s_r.mode)
					FPI_MODE_DET: s_nxt.dn_inst = `FPI_INST_DN_DET;
					FPI_MODE_AUX: s_nxt.dn_inst = `FPI_INST_DN_AUX;
					default:      s_nxt.dn_inst = `FPI_INST_DN_LEG;
				endcase
				case (s_r.cnt)
					`FPI_W_CONN0: s_nxt.dn_word = s_r.conn[15:0];
					`FPI_W_CONN1: s_nxt.dn_word = s_r.conn[31:16];
					default: begin
						s_nxt.dn_word = 16'h0000;
						s_nxt.dn_word[`FPI_RST_BIT] = s_r.frst;
					end
				endcase
				s_nxt.dn_last = (s_r.cnt == dlen - 7'h01);
				s_nxt.cnt     = s_r.cnt + 7'h01;
				if (s_nxt.dn_last) begin
					s_nxt.cnt = 7'h00;
					s_nxt.st  = FPI_M_WAIT;
				end
			end
			FPI_M_WAIT: begin
				if (lk.up_valid) begin
					if (s_r.cnt < `FPI_UP_LEN_AUX) begin
						s_nxt.mem[s_r.cnt] = lk.up_word;
					end
					s_nxt.cnt = s_r.cnt + 7'h01;
					if (lk.up_last) begin
						s_nxt.st      = FPI_M_IDLE;
						s_nxt.busy    = 1'b0;
						s_nxt.done    = 1'b1;
						s_nxt.up_len  = s_r.cnt + 7'h01;
						s_nxt.up_inst = lk.up_inst;
					end
				end
			end
			default: s_nxt.st = FPI_M_IDLE;
		endcase

		if (s_r.wr_pend) begin
			case (s_r.addr)
				`FPI_A_CONN: s_nxt.conn = hwdata;
				`FPI_A_CTRL: begin
					s_nxt.frst = hwdata[`FPI_C_FRST];
					if (!s_r.busy) begin
						s_nxt.mode = (hwdata[`FPI_C_MODE +: 2] == 2'h3) ? FPI_MODE_LEG
							: fpi_mode_type'(hwdata[`FPI_C_MODE +: 2]);
					end
					if (hwdata[`FPI_C_ABORT]) begin
						// Recovery when the device drops a frame
						s_nxt.st   = FPI_M_IDLE;
						s_nxt.busy = 1'b0;
					end else if (hwdata[`FPI_C_GO] && !s_r.busy) begin
						s_nxt.st   = FPI_M_SEND;
						s_nxt.cnt  = 7'h00;
						s_nxt.busy = 1'b1;
						s_nxt.done = 1'b0;
					end
				end
				default: s_nxt.st = s_nxt.st;
			endcase
		end
	end

	// ============================================================
	// State register
	always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
		if (!lk.hresetn) begin
			s_r           <= '0;
			s_r.hreadyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign hreadyout   = s_r.hreadyout;
	assign hresp       = 1'b0;
	assign hrdata      = s_r.hrdata;
	assign lk.dn_valid = s_r.dn_valid;
	assign lk.dn_last  = s_r.dn_last;
	assign lk.dn_inst  = s_r.dn_inst;
	assign lk.dn_word  = s_r.dn_word;

endmodule : fpi_master

// File: sim/fpi_link_properties.sv
`timescale 1ns/1ps

module fpi_link_properties (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Downlink
	input wire logic        dn_valid,
	input wire logic        dn_last,
	input wire logic [7:0]  dn_inst,
	input wire logic [15:0] dn_word,
	// Uplink
	input wire logic        up_valid,
	input wire logic        up_last,
	input wire logic [7:0]  up_inst,
	input wire logic [15:0] up_word
);
	logic [6:0]  dn_cnt_r;
	logic [6:0]  up_cnt_r;
	logic [31:0] conn_r;
	logic [7:0]  inst_r;
	logic        hb_r;
	logic        hb_seen_r;
	logic        dn_ok;

	// ============================================================
	// Frame trackers
	assign dn_ok = (dn_inst == 8'h82) ? (dn_cnt_r == 7'h01)
		: (dn_cnt_r == 7'h02 && (dn_inst == 8'h66 || dn_inst == 8'h68));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dn_cnt_r <= 7'h00;
			up_cnt_r <= 7'h00;
			conn_r <= 32'h00000000;
			inst_r <= 8'h00;
			hb_r <= 1'b0;
			hb_seen_r <= 1'b0;
		end else begin
			if (dn_valid)
				dn_cnt_r <= dn_last ? 7'h00 : dn_cnt_r + 7'h01;
			if (dn_valid && dn_cnt_r == 7'h00)
				conn_r[15:0] <= dn_word;
			if (dn_valid && dn_cnt_r == 7'h01)
				conn_r[31:16] <= dn_word;
			if (dn_valid && dn_last)
				inst_r <= dn_inst;
			if (up_valid)
				up_cnt_r <= up_last ? 7'h00 : up_cnt_r + 7'h01;
			if (up_valid && up_cnt_r == 7'h71) begin
				hb_r <= up_word[7];
				hb_seen_r <= 1'b1;
			end
		end
	end

	// ============================================================
	// Link properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// One idle cycle, then the answer starts
	sequence s_turn;
		!up_valid ##1 !up_valid ##1 up_valid;
	endsequence

	dn_len_a: assert property (dn_valid && dn_last |-> dn_ok)
		else $error("downlink frame length or instance wrong");
	dn_hold_a: assert property (dn_valid && !dn_last |=> dn_valid && $stable(dn_inst))
		else $error("downlink frame broken");
	turn_gap_a: assert property (dn_valid && dn_last && dn_ok |-> s_turn)
		else $error("uplink did not follow a valid downlink");
	up_len_a: assert property (up_valid && up_last |-> (up_inst == 8'h65 && up_cnt_r == 7'h71)
		|| (up_inst == 8'h67 && up_cnt_r == 7'h75) || (up_inst == 8'h81 && up_cnt_r == 7'h77))
		else $error("uplink length wrong");
	up_cont_a: assert property (up_valid && !up_last |=> up_valid && $stable(up_inst))
		else $error("uplink frame broken");
	up_pair_a: assert property (up_valid |-> up_inst == ((inst_r == 8'h66) ? 8'h65
		: (inst_r == 8'h68) ? 8'h67 : 8'h81))
		else $error("uplink instance does not pair");
	conn_echo_a: assert property (up_valid && up_cnt_r < 7'h02
		|-> up_word == (up_cnt_r[0] ? conn_r[31:16] : conn_r[15:0]))
		else $error("connection status not echoed");
	sum_zero_a: assert property (up_valid && up_cnt_r >= 7'h6e && up_cnt_r <= 7'h70
		|-> !up_word[6] && !up_word[14])
		else $error("summary spare bit set");
	mach_zero_a: assert property (up_valid && up_cnt_r == 7'h71
		|-> up_word[15:8] == 8'h00 && !up_word[6])
		else $error("machine summary spare bit set");
	heart_beat_a: assert property (up_valid && up_cnt_r == 7'h71 && hb_seen_r
		|-> up_word[7] != hb_r)
		else $error("heartbeat did not toggle");
	pad_zero_a: assert property (up_valid && up_inst == 8'h81 && up_cnt_r > 7'h75
		|-> up_word == 16'h0000)
		else $error("padding word not zero");
endmodule // fpi_link_properties

// File: sim/fieldbus_process_image_tb_top.sv
`timescale 1ns/1ps
`include "fpi_regs.svh"

module fieldbus_process_image_tb_top;
	logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, power_in;
	logic [31:0]   haddr, hwdata, hrdata, conn_stat;
	logic [1:0]    htrans;
	logic [2:0]    hsize, anl_crit, anl_maint, anl_alm1, anl_alm2, anl_active;
	logic [1535:0] conc_in;
	logic [95:0]   alm1_in, alm2_in;
	logic [5:0]    unit_crit, unit_maint, unit_active;
	logic [63:0]   fault_ind_in;
	logic          fault_clr, frame_err, mach_crit, mach_maint, mach_alm1, mach_alm2, power_on;
	int            n_fail, checked, n_clr, n_err;

	fpi_link_if fpi_link_if_i (.hclk(hclk), .hresetn(hresetn));
	fpi_device fpi_device_i (.lk(fpi_link_if_i.dev), .conc_in(conc_in), .alm1_in(alm1_in),
		.alm2_in(alm2_in), .unit_crit(unit_crit), .unit_maint(unit_maint),
		.unit_active(unit_active), .power_in(power_in), .fault_ind_in(fault_ind_in),
		.fault_clr(fault_clr), .frame_err(frame_err), .conn_stat(conn_stat),
		.mach_crit(mach_crit), .mach_maint(mach_maint), .mach_alm1(mach_alm1),
		.mach_alm2(mach_alm2), .power_on(power_on), .anl_crit(anl_crit),
		.anl_maint(anl_maint), .anl_alm1(anl_alm1), .anl_alm2(anl_alm2),
		.anl_active(anl_active));
	fpi_master fpi_master_i (.lk(fpi_link_if_i.mst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	fpi_link_properties fpi_link_properties_i (.hclk(hclk), .hresetn(hresetn),
		.dn_valid(fpi_link_if_i.dn_valid), .dn_last(fpi_link_if_i.dn_last),
		.dn_inst(fpi_link_if_i.dn_inst), .dn_word(fpi_link_if_i.dn_word),
		.up_valid(fpi_link_if_i.up_valid), .up_last(fpi_link_if_i.up_last),
		.up_inst(fpi_link_if_i.up_inst), .up_word(fpi_link_if_i.up_word));

	always #2.5 hclk = ~hclk;
	always @(posedge hclk) begin
		if (fault_clr === 1'b1)
			n_clr++;
		if (frame_err === 1'b1)
			n_err++;
	end

	// ============================================================
	// Reporting
	task results;
		$display("checked %0d, failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task stop_run(input string what);
		n_fail++;
		$display("CHECK FAILED at %0t: %s timed out", $time, what);
		results;
	endtask

	// ============================================================
	// Bus access, waits only on the slave's own ready
	task wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 40)
				stop_run("bus");
			@(posedge hclk);
		end
	endtask
	task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask

	// ============================================================
	// Expected uplink contents
	function automatic logic [7:0] ub(int u);
		return {2'h0, power_in, unit_active[u], |alm2_in[u*16+:16], |alm1_in[u*16+:16],
			unit_maint[u], unit_crit[u]};
	endfunction
	function automatic logic [15:0] exp_w(int i, logic [31:0] c);
		if (i < 2) return c[i*16+:16];
		if (i < 98) return conc_in[(i-2)*16+:16];
		if (i < 104) return alm1_in[(i-98)*16+:16];
		if (i < 110) return alm2_in[(i-104)*16+:16];
		if (i < 113) return {ub(2*i-219), ub(2*i-220)};
		if (i == 113) return {8'h00, 2'h0, power_in, |unit_active, |alm2_in, |alm1_in,
			|unit_maint, |unit_crit};
		if (i < 118) return fault_ind_in[(i-114)*16+:16];
		return 16'h0000;
	endfunction
	// Heartbeat is left to the checker
	function automatic logic [15:0] exp_mask(int i);
		if (i >= 110 && i <= 112) return 16'h7f7f;
		if (i == 113) return 16'hff7f;
		return 16'hffff;
	endfunction
	function automatic logic [2:0] by_anl(logic [5:0] u);
		return {|u[5:4], |u[3:2], |u[1:0]};
	endfunction

	// ============================================================
	// Scenarios
	task set_flags(input logic [95:0] a1, input logic [95:0] a2, input logic [5:0] c,
		input logic [5:0] mt, input logic [5:0] act, input logic pw);
		@(posedge hclk);
		alm1_in <= a1;
		alm2_in <= a2;
		unit_crit <= c;
		unit_maint <= mt;
		unit_active <= act;
		power_in <= pw;
		repeat (2) @(posedge hclk);
		cmp({mach_crit, mach_maint, mach_alm1, mach_alm2, power_on},
			{|c, |mt, |a1, |a2, pw}, "machine flags");
		cmp({anl_crit, anl_maint, anl_alm1, anl_alm2, anl_active}, {by_anl(c), by_anl(mt),
			|a1[95:64], |a1[63:32], |a1[31:0], |a2[95:64], |a2[63:32], |a2[31:0],
			by_anl(act)}, "analyzer flags");
	endtask
	task run_frame(input logic [1:0] mode, input logic frst, input logic [31:0] conn,
		input logic [6:0] len, input logic [7:0] inst, input int clr);
		logic [31:0] q;
		int i;
		ahb(1'b1, `FPI_A_CONN, conn, q);
		ahb(1'b1, `FPI_A_CTRL, {23'h000000, frst, 5'h00, mode, 1'b1}, q);
		i = 0;
		ahb(1'b0, `FPI_A_STAT, 32'h0, q);
		while (q[1] !== 1'b1) begin
			i++;
			if (i > 100)
				stop_run("frame");
			ahb(1'b0, `FPI_A_STAT, 32'h0, q);
		end
		cmp(q[23:8], {inst, 1'b0, len}, "length and instance");
		cmp(conn_stat, conn, "connection status");
		cmp(n_clr, clr, "fault clear pulses");
		for (i = 0; i < len; i++) begin
			ahb(1'b0, `FPI_A_BUF + 12'(4*i), 32'h0, q);
			cmp(q[15:0] & exp_mask(i), exp_w(i, conn) & exp_mask(i),
				$sformatf("word %0d", i));
		end
	endtask
	task unmapped_read;
		logic [31:0] q;
		ahb(1'b0, 12'h100, 32'h0, q);
		cmp(q, 32'h0, "unmapped read");
		cmp({31'h0, hresp}, 32'h0, "bus response");
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{alm1_in, alm2_in, unit_crit, unit_maint, unit_active, power_in} = '0;
		fault_ind_in = 64'h8001_0000_00f0_0001;
		for (int p = 0; p < 96; p++)
			conc_in[p*16+:16] = 16'(p * 37 + 5);
		{n_fail, checked, n_clr, n_err} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		set_flags(96'h0, 96'h0, 6'h00, 6'h00, 6'h00, 1'b0);
		set_flags({64'h0, 32'h8000_0001}, {32'h0001_0000, 64'h0}, 6'h02, 6'h20, 6'h15,
			1'b1);
		unmapped_read;
		run_frame(2'h0, 1'b1, 32'h1234_5678, 7'h72, 8'h65, 0);
		run_frame(2'h1, 1'b0, 32'h9abc_def0, 7'h76, 8'h67, 1);
		run_frame(2'h2, 1'b1, 32'h0f0f_a5a5, 7'h78, 8'h81, 1);
		set_flags({32'h0, 32'h0001_0000, 32'h0}, 96'h0, 6'h10, 6'h01, 6'h08, 1'b0);
		run_frame(2'h3, 1'b0, 32'h5555_aaaa, 7'h72, 8'h65, 1);
		cmp(n_err, 0, "frame errors");
		results;
	end
endmodule // fieldbus_process_image_tb_top
